// File: logic/i2cx_pkg.sv
// Purpose: shared constants and types of the serial port expander
// Assumes: one 8-bit quasi-bidirectional port behind a two-wire serial link
// Notes:   link states step in Gray order along the write byte path; AACK to RDATA flips all three bits
package i2cx_pkg;

  localparam int unsigned I2CX_PORT_W   = 8;
  localparam int unsigned I2CX_ADDR_W   = 7;
  localparam int unsigned I2CX_SEL_W    = 3;
  localparam logic [7:0]  I2CX_PORT_RST = 8'hFF;
  localparam logic [2:0]  I2CX_SEL_RST  = 3'h0;
  localparam logic [2:0]  I2CX_BIT_LAST = 3'h7;
  localparam logic [2:0]  I2CX_BIT_ONE  = 3'h1;
  localparam logic [2:0]  I2CX_BIT_ZERO = 3'h0;
  localparam logic        I2CX_RW_READ  = 1'b1;
  localparam logic [1:0]  I2CX_WR_SETTLE = 2'h3;

  typedef enum logic [2:0] {
    I2CX_ADDR  = 3'h0,
    I2CX_AACK  = 3'h1,
    I2CX_WDATA = 3'h3,
    I2CX_WACK  = 3'h2,
    I2CX_RDATA = 3'h6,
    I2CX_RACK  = 3'h7,
    I2CX_IDLE  = 3'h5
  } i2cx_link_st_t;

endpackage

// File: logic/i2cx_sync.sv
// Purpose: two-stage synchroniser for a group of asynchronous levels
// Assumes: inputs are quasi-static compared with mclk
// Notes:   first stage feeds only the second stage
module i2cx_sync import i2cx_pkg::*; #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } i2cx_sync_st_t;

  i2cx_sync_st_t st_q;
  i2cx_sync_st_t st_d;

  if (W < 1) begin : g_chk
    $error("i2cx_sync: width must be at least one");
  end

  always_comb begin
    st_d = st_q;
    if (ce) begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_q <= {RST_VAL, RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;

endmodule

// File: logic/i2cx_expander.sv
// Purpose: device side of an 8-bit quasi-bidirectional expander on a serial link
// Assumes: scl_clk is the link clock, idle-high and still outside frames
// Notes:   port snapshot is taken at each START and served for the whole frame

// Summary of operation
// [R1] After power-up the host writes one byte with 1 on every input line and wanted levels elsewhere.
// [R2] A write is START, address with write bit, ack, one data byte, ack, STOP; the byte reaches the port.
// [R3] A read is START, address with read bit, ack, the port byte from the device, host nack, STOP.
// [R4] A change on an input line drives the change interrupt output low.
// [R5] The host waits while the interrupt is high and reads the port once it is low.
// [R6] On a low bit 0 the host writes new outputs while keeping 1 on bits 1 and 0.
// [R7] Data bit 7 maps to port line 7 down to bit 0 on port line 0.
// [R8] The host writes equal values to port lines that are tied together.
// [R9] The interrupt releases when inputs return to their former state or the port is read or written.
// [R10] A read reports real pin levels, and reset leaves every line released high as an input.
// [R11] The host treats a missing address ack as failure, issues STOP and retries later.
module i2cx_expander import i2cx_pkg::*; #(
  parameter logic [3:0] DEV_ADDR_HI = 4'h4  // arbitrary fixed address part
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   scl_clk,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_n,
  input  wire logic [I2CX_SEL_W-1:0]  addr_sel,
  input  wire logic [I2CX_PORT_W-1:0] port_i,
  output logic      [I2CX_PORT_W-1:0] port_o,
  output logic      [I2CX_PORT_W-1:0] port_oe_n,
  output logic                        int_o,
  output logic                        int_oe_n
);

  localparam int unsigned SYNC_W = 2 + I2CX_SEL_W + I2CX_PORT_W;

  if (I2CX_PORT_W != 8 || I2CX_ADDR_W != 4 + I2CX_SEL_W) begin : g_chk
    $error("i2cx_expander: port must be one byte wide");
  end

  typedef struct packed {
    logic                   scl_d;
    logic                   sda_d;
    logic                   idle;
    logic                   start;
    logic [I2CX_PORT_W-1:0] port;
    logic [I2CX_PORT_W-1:0] ref_v;
    logic [I2CX_PORT_W-1:0] snap;
    logic [I2CX_SEL_W-1:0]  addr;
    logic [2:0]             wr_s;
    logic [2:0]             rd_s;
    logic [1:0]             hold;
    logic                   int_act;
  } i2cx_core_t;

  typedef struct packed {
    i2cx_link_st_t          st;
    logic [2:0]             cnt;
    logic [I2CX_PORT_W-1:0] sr;
    logic                   rw;
    logic [I2CX_PORT_W-1:0] wr_byte;
    logic                   wr_tgl;
    logic                   rd_tgl;
  } i2cx_link_t;

  i2cx_core_t             c_q;
  i2cx_core_t             c_d;
  i2cx_link_t             l_q;
  i2cx_link_t             l_d;
  logic                   sda_oe_n_q;
  logic [SYNC_W-1:0]      sy;
  logic                   scl_s;
  logic                   sda_s;
  logic [I2CX_SEL_W-1:0]  addr_s;
  logic [I2CX_PORT_W-1:0] pin_s;
  logic                   start_ev;
  logic                   stop_ev;
  logic                   wr_ev;
  logic                   rd_ev;
  logic                   mismatch;
  logic                   link_rst;
  logic                   ack_drv;
  logic [I2CX_ADDR_W-1:0] own_addr;

  ////////////////////////////////////////////////////////////////////////////
  // pins into mclk domain

  i2cx_sync #(
    .W       (SYNC_W),
    .RST_VAL ({2'h3, I2CX_SEL_RST, I2CX_PORT_RST})
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .ce   (ce),
    .d    ({scl_clk, sda_i, addr_sel, port_i}),
    .q    (sy)
  );

  assign scl_s  = sy[SYNC_W-1];
  assign sda_s  = sy[SYNC_W-2];
  assign addr_s = sy[I2CX_PORT_W +: I2CX_SEL_W];
  assign pin_s  = sy[I2CX_PORT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // mclk domain: frame detect, port latch, interrupt

  assign start_ev = scl_s & c_q.scl_d & c_q.sda_d & ~sda_s;
  assign stop_ev  = scl_s & c_q.scl_d & ~c_q.sda_d & sda_s;
  assign wr_ev    = c_q.wr_s[1] ^ c_q.wr_s[2];
  assign rd_ev    = c_q.rd_s[1] ^ c_q.rd_s[2];
  // only released lines count as inputs, so own output changes stay quiet
  assign mismatch = |((pin_s ^ c_q.ref_v) & c_q.port);

  always_comb begin
    c_d = c_q;
    if (ce) begin
      c_d.scl_d = scl_s;
      c_d.sda_d = sda_s;
      c_d.start = start_ev;
      c_d.wr_s  = link_rst ? 3'h0 : {c_q.wr_s[1], c_q.wr_s[0], l_q.wr_tgl};
      c_d.rd_s  = link_rst ? 3'h0 : {c_q.rd_s[1], c_q.rd_s[0], l_q.rd_tgl};
      if (start_ev) begin
        c_d.idle = 1'b0;
        c_d.snap = pin_s;  // [R10]
      end
      if (stop_ev) begin
        c_d.idle = 1'b1;
      end
      // straps only move between frames so the link sees a still address
      if (c_q.idle) begin
        c_d.addr = addr_s;
      end
      // freed lines rise after a write; re-take the reference once pins settle
      if (c_q.hold != 2'h0) begin
        c_d.hold = c_q.hold - 2'h1;
      end
      if (c_q.hold == 2'h1) begin
        c_d.ref_v = pin_s;  // [R9]
      end
      // wr_byte holds still for a whole byte, ample time for the toggle
      if (wr_ev) begin
        c_d.port  = l_q.wr_byte;  // [R2] [R7]
        c_d.ref_v = pin_s;        // [R9]
        c_d.hold  = I2CX_WR_SETTLE;
      end else if (rd_ev) begin
        c_d.ref_v = c_q.snap;     // [R9]
      end
      c_d.int_act = mismatch & ~wr_ev & ~rd_ev & (c_q.hold == 2'h0);  // [R4] [R9]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_q <= '{scl_d: 1'b1, sda_d: 1'b1, idle: 1'b1, start: 1'b0,
               port: I2CX_PORT_RST, ref_v: I2CX_PORT_RST, snap: I2CX_PORT_RST, hold: 2'h0,
               addr: I2CX_SEL_RST, wr_s: 3'h0, rd_s: 3'h0, int_act: 1'b0};  // [R10]
    end else begin
      c_q <= c_d;
    end
  end

  assign link_rst  = c_q.idle | c_q.start;
  assign own_addr  = {DEV_ADDR_HI, c_q.addr};
  assign port_o    = '0;
  assign port_oe_n = c_q.port;  // [R10]
  assign int_o     = 1'b0;
  assign int_oe_n  = ~c_q.int_act;  // [R4]

  ////////////////////////////////////////////////////////////////////////////
  // link domain: bit engine on scl_clk, held in reset between frames

  always_comb begin
    l_d = l_q;
    case (l_q.st)
      I2CX_ADDR: begin
        l_d.sr  = {l_q.sr[6:0], sda_i};
        l_d.cnt = l_q.cnt + I2CX_BIT_ONE;
        if (l_q.cnt == I2CX_BIT_LAST) begin
          if (l_q.sr[6:0] == own_addr) begin
            l_d.st = I2CX_AACK;
            l_d.rw = sda_i;
          end else begin
            l_d.st = I2CX_IDLE;
          end
        end
      end
      I2CX_AACK: begin
        l_d.cnt = I2CX_BIT_ZERO;
        if (l_q.rw == I2CX_RW_READ) begin
          l_d.st     = I2CX_RDATA;
          l_d.rd_tgl = ~l_q.rd_tgl;  // [R9]
        end else begin
          l_d.st = I2CX_WDATA;
        end
      end
      I2CX_WDATA: begin
        l_d.sr  = {l_q.sr[6:0], sda_i};
        l_d.cnt = l_q.cnt + I2CX_BIT_ONE;
        if (l_q.cnt == I2CX_BIT_LAST) begin
          l_d.wr_byte = {l_q.sr[6:0], sda_i};  // [R7]
          l_d.st      = I2CX_WACK;
        end
      end
      I2CX_WACK: begin
        // port moves only once the byte is acknowledged
        l_d.wr_tgl = ~l_q.wr_tgl;  // [R2]
        l_d.cnt    = I2CX_BIT_ZERO;
        l_d.st     = I2CX_WDATA;
      end
      I2CX_RDATA: begin
        l_d.cnt = l_q.cnt + I2CX_BIT_ONE;
        if (l_q.cnt == I2CX_BIT_LAST) begin
          l_d.st = I2CX_RACK;
        end
      end
      I2CX_RACK: begin
        if (sda_i) begin
          l_d.st = I2CX_IDLE;  // [R3]
        end else begin
          l_d.st     = I2CX_RDATA;
          l_d.cnt    = I2CX_BIT_ZERO;
          l_d.rd_tgl = ~l_q.rd_tgl;
        end
      end
      I2CX_IDLE: begin
        l_d.st = I2CX_IDLE;
      end
      default: begin
        l_d.st = I2CX_IDLE;
      end
    endcase
  end

  always_ff @(posedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      l_q <= '{st: I2CX_ADDR, cnt: I2CX_BIT_ZERO, sr: 8'h00, rw: 1'b0,
               wr_byte: 8'h00, wr_tgl: 1'b0, rd_tgl: 1'b0};
    end else begin
      l_q <= l_d;
    end
  end

  // toggles restart at zero each frame; mclk clears its copies under link_rst,
  // so that drop is no event (a toggle younger than the sync would be lost)
  assign ack_drv = (l_q.st == I2CX_AACK) | (l_q.st == I2CX_WACK);

  // data changes while scl is low, so drive on the falling edge
  always_ff @(negedge scl_clk or posedge link_rst) begin
    if (link_rst) begin
      sda_oe_n_q <= 1'b1;
    end else if (ack_drv) begin
      sda_oe_n_q <= 1'b0;  // [R2] [R3]
    end else if (l_q.st == I2CX_RDATA) begin
      sda_oe_n_q <= c_q.snap[I2CX_BIT_LAST - l_q.cnt];  // [R3] [R7] [R10]
    end else begin
      sda_oe_n_q <= 1'b1;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_n = sda_oe_n_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_port_write: assert property (@(posedge mclk) disable iff (rst) // [R2]
    ce && wr_ev |=> port_oe_n == $past(l_q.wr_byte))
    else $error("port not loaded from written byte");

  chk_int_on_change: assert property (@(posedge mclk) disable iff (rst) // [R4]
    ce && mismatch && !wr_ev && !rd_ev && c_q.hold == 2'h0 |=> !int_oe_n)
    else $error("interrupt missing after input change");

  chk_int_rd_clear: assert property (@(posedge mclk) disable iff (rst) // [R9]
    ce && (rd_ev || wr_ev) |=> int_oe_n)
    else $error("interrupt not released by port access");

  chk_int_return: assert property (@(posedge mclk) disable iff (rst) // [R9]
    ce && !mismatch |=> int_oe_n)
    else $error("interrupt held with inputs at former state");

  chk_snap_start: assert property (@(posedge mclk) disable iff (rst) // [R10]
    ce && start_ev |=> c_q.snap == $past(pin_s) && !c_q.idle)
    else $error("pin levels not captured at frame start");

  chk_ack_drive: assert property (@(posedge scl_clk) disable iff (link_rst) // [R2]
    (l_q.st == I2CX_WACK) || (l_q.st == I2CX_AACK) |-> !sda_oe_n)
    else $error("acknowledge not driven");

  chk_read_bit: assert property (@(posedge scl_clk) disable iff (link_rst) // [R7]
    l_q.st == I2CX_RDATA |-> sda_oe_n == c_q.snap[I2CX_BIT_LAST - l_q.cnt])
    else $error("read bit out of order");

  chk_nack_end: assert property (@(posedge scl_clk) disable iff (link_rst) // [R3]
    l_q.st == I2CX_RACK && sda_i |=> l_q.st == I2CX_IDLE ##0 sda_oe_n)
    else $error("transmitter kept sda after host nack");

endmodule

// File: testbench/i2cx_host.sv
// Purpose: host model for the serial link of the port expander
// Assumes: sda is open drain with a pull-up; scl stands high between frames
// Notes:   30 ns bit cell; wider phases around START and STOP
module i2cx_host (
  output logic      scl_clk,
  output logic      sda_drv_n,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl_clk   = 1'b1;
    sda_drv_n = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sda only moves while scl is low; taken at the rising edge
  task automatic bit_x(input logic b, output logic r);
    #7.3 sda_drv_n <= b;
    #7.7 r = sda_i;
    scl_clk <= 1'b1;
    #15 scl_clk <= 1'b0;
  endtask

  task automatic start_c;
    #40 sda_drv_n <= 1'b0;
    #40 scl_clk <= 1'b0;
  endtask

  task automatic stop_c;
    #7.3 sda_drv_n <= 1'b0;
    #40 scl_clk <= 1'b1;
    #40 sda_drv_n <= 1'b1;
    #40;
  endtask

  // w of all ones leaves sda to the device; last high is a release or nack
  task automatic byte_x(input logic [7:0] w, input logic last, output logic [7:0] r,
                        output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(w[i], s);
      r[i] = s;
    end
    bit_x(last, s);
    ack = !s;
  endtask

  task automatic xfer(input logic [7:0] adr, input logic [7:0] w,
                      output logic [7:0] r, output logic ok);
    logic [7:0] junk;
    logic       a2;
    start_c();
    byte_x(adr, 1'b1, junk, ok);
    if (ok) begin
      byte_x(adr[0] ? 8'hFF : w, 1'b1, r, a2);
      if (!adr[0]) ok = a2;
    end
    stop_c();
  endtask
endmodule

// File: testbench/tb_top.sv
// Purpose: self-checking bench for the serial port expander
// Assumes: device address {4'h4, addr_sel}; port lines have weak pull-ups
// Notes:   ext_n models outside sinks on the port lines
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk        = 1'b0;
  logic       rst         = 1'b1;
  logic [2:0] addr_sel    = 3'h0;
  logic [7:0] ext_n       = 8'hFF;
  logic [7:0] rd;
  logic       ok;
  int         fail_count  = 0;
  int         check_count = 0;
  wire        scl_w;
  wire        host_n;
  wire        dev_n;
  wire        int_n;
  wire        sda_lo;
  wire        int_lo;
  wire  [7:0] port_lo;
  wire  [7:0] oe_n;
  wire        sda_w       = host_n & dev_n;
  wire  [7:0] pins        = oe_n & ext_n;

  i2cx_host u_host (.scl_clk(scl_w), .sda_drv_n(host_n), .sda_i(sda_w));
  i2cx_expander u_dut (
    .mclk(mclk), .rst(rst), .ce(1'b1), .scl_clk(scl_w), .sda_i(sda_w), .sda_o(sda_lo),
    .sda_oe_n(dev_n), .addr_sel(addr_sel), .port_i(pins), .port_o(port_lo),
    .port_oe_n(oe_n), .int_o(int_lo), .int_oe_n(int_n));

  initial begin
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // bounded wait; a miss shows in the compare that follows
  task automatic wait_int(input logic lvl);
    for (int n = 0; n < 40 && int_n !== lvl; n++) @(posedge mclk);
    #1;
  endtask

  task automatic t_reset;
    chk(oe_n, i2cx_pkg::I2CX_PORT_RST);
    chk({7'h00, int_n}, 8'h01);
    chk(port_lo, 8'h00);
    chk({6'h00, sda_lo, int_lo}, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_config;
    u_host.xfer(8'h40, 8'hA3, rd, ok);
    chk({7'h00, ok}, 8'h01);
    chk(oe_n, 8'hA3);
    chk(pins, 8'hA3);
    $display("t_config done");
  endtask

  task automatic t_int_read;
    @(posedge mclk) ext_n[0] <= 1'b0;
    wait_int(1'b0);
    chk({7'h00, int_n}, 8'h00);
    u_host.xfer(8'h41, 8'hFF, rd, ok);
    chk({7'h00, ok}, 8'h01);
    chk(rd, 8'hA2);
    chk({7'h00, int_n}, 8'h01);
    $display("t_int_read done");
  endtask

  // lines 1 and 0 stay released together as inputs
  task automatic t_cond_write;
    if (rd[0] === 1'b0) begin
      u_host.xfer(8'h40, 8'h2B, rd, ok);
    end
    chk(oe_n, 8'h2B);
    chk(pins, 8'h2A);
    chk({7'h00, int_n}, 8'h01);
    $display("t_cond_write done");
  endtask

  task automatic t_return;
    @(posedge mclk) ext_n[0] <= 1'b1;
    wait_int(1'b0);
    chk({7'h00, int_n}, 8'h00);
    @(posedge mclk) ext_n[0] <= 1'b0;
    wait_int(1'b1);
    chk({7'h00, int_n}, 8'h01);
    $display("t_return done");
  endtask

  task automatic t_addr;
    @(posedge mclk) addr_sel <= 3'h3;
    repeat (8) @(posedge mclk);
    u_host.xfer(8'h40, 8'h00, rd, ok);
    chk({7'h00, ok}, 8'h00);
    chk(oe_n, 8'h2B);
    // address {4'h4, 3'h3} with the write bit
    u_host.xfer(8'h46, 8'hFF, rd, ok);
    chk({7'h00, ok}, 8'h01);
    chk(oe_n, 8'hFF);
    chk({7'h00, int_n}, 8'h01);
    $display("t_addr done");
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_config();
    t_int_read();
    t_cond_write();
    t_return();
    t_addr();
    end_of_test();
  end

  // whole run needs under 10 us
  initial begin
    #50000;
    fail_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    end_of_test();
  end
endmodule
